// file: verilog/gio_pkg.sv
// shared types and constants for the general-purpose port bank
package gio_pkg;

  localparam int unsigned NPORT = 32;
  localparam int unsigned IDXW = 5;
  localparam int unsigned MODEW = 4;

  // reset values
  localparam logic [NPORT-1:0] OUT_RST = 32'h0000_0000;
  localparam logic [NPORT-1:0] LOCK_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    GIO_OP_NOP = 4'h0,
    GIO_OP_BULK_READ = 4'h1,
    GIO_OP_BULK_WRITE = 4'h2,
    GIO_OP_SET_OUTPUT = 4'h3,
    GIO_OP_GET_INPUT = 4'h4,
    GIO_OP_GET_OUTPUT = 4'h5,
    GIO_OP_GET_MODE = 4'h6,
    GIO_OP_SET_MODE = 4'h7,
    GIO_OP_LOCK = 4'h8,
    GIO_OP_UNLOCK = 4'h9
  } gio_op_t;

  typedef enum logic [MODEW-1:0] {
    GIO_MODE_INPUT = 4'h0,
    GIO_MODE_INPUT_WITH_PULLUP = 4'h1,
    GIO_MODE_INPUT_WITH_PULLDOWN = 4'h2,
    GIO_MODE_OUTPUT = 4'h3,
    GIO_MODE_OUTPUT_PUSH_PULL = 4'h4,
    GIO_MODE_OUTPUT_OPEN_DRAIN = 4'h5,
    GIO_MODE_LED = 4'h6,
    GIO_MODE_HW_PERIPHERAL = 4'hE,
    GIO_MODE_SOFT_TIMER_OUTPUT = 4'hF
  } gio_mode_t;

  localparam gio_mode_t MODE_RST = GIO_MODE_INPUT;

  typedef enum logic [1:0] {
    GIO_DFLT_NONE = 2'h0,
    GIO_DFLT_LOW = 2'h1,
    GIO_DFLT_HIGH = 2'h2
  } gio_dflt_t;

  typedef struct packed {
    gio_mode_t mode;
    gio_dflt_t dflt;
  } gio_cfg_t;

  typedef struct packed {
    gio_op_t op;
    logic [IDXW-1:0] first;
    logic [IDXW-1:0] last;
    logic [NPORT-1:0] data;
    gio_cfg_t cfg;
  } gio_cmd_t;

endpackage

// file: verilog/gio_bit.sv
// one port: output level, lock, configured mode and pad controls
`timescale 1ns/1ps
`default_nettype none

module gio_bit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_val,
  input wire logic cfg_en,
  input wire gio_pkg::gio_cfg_t cfg,
  input wire logic lock_set,
  input wire logic lock_clr,
  input wire logic locked,
  output logic out_q,
  output logic lock_q,
  output var gio_pkg::gio_mode_t mode_q,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pull_up,
  output logic pull_dn
);

  logic out_d;
  logic lock_d;
  logic dflt_hit;
  logic is_out;
  logic is_od;

  assign dflt_hit = cfg_en && (cfg.dflt != gio_pkg::GIO_DFLT_NONE) && !locked;
  // a write beats a default in the same cycle, but both are blocked by the lock
  assign out_d = (wr_en && !locked) ? wr_val : // R9
                 dflt_hit ? (cfg.dflt == gio_pkg::GIO_DFLT_HIGH) : out_q; // R11
  assign lock_d = lock_set ? 1'b1 : (lock_clr ? 1'b0 : lock_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= 1'b0; // R13
      lock_q <= 1'b0; // R13
      mode_q <= gio_pkg::MODE_RST;
    end else begin
      out_q <= out_d;
      lock_q <= lock_d;
      if (cfg_en) begin
        mode_q <= cfg.mode;
      end
    end
  end

  assign is_od = (mode_q == gio_pkg::GIO_MODE_OUTPUT_OPEN_DRAIN);
  assign is_out = (mode_q == gio_pkg::GIO_MODE_OUTPUT) ||
                  (mode_q == gio_pkg::GIO_MODE_OUTPUT_PUSH_PULL) ||
                  (mode_q == gio_pkg::GIO_MODE_LED) || is_od;
  // open drain only pulls low; high is left to the external resistor
  assign pin_out = is_od ? 1'b0 : out_q;
  assign pin_oe_n = !(is_out && !(is_od && out_q));
  assign pull_up = (mode_q == gio_pkg::GIO_MODE_INPUT_WITH_PULLUP);
  assign pull_dn = (mode_q == gio_pkg::GIO_MODE_INPUT_WITH_PULLDOWN);

endmodule

`default_nettype wire

// file: verilog/gio_port.sv
// 32-port general-purpose I/O bank with command port, queries and output lock
// Operation
// [R1] bulk read returns all 32 port levels as one word, one bit each.
// [R2] bulk write updates every port output from its bit of the word.
// [R3] single-port write sets one port high or low, others unchanged.
// [R4] input query returns the selected port's sampled pin level, 0 or 1.
// [R5] output query returns the selected port's driven output level, 0 or 1.
// [R6] mode query on a UART, SPI or I2C owned port reports peripheral mode.
// [R7] timer-owned port reports timer mode; otherwise the configured type.
// [R8] software queries input level on inputs, output level on outputs.
// [R9] locked ports ignore output writes; after unlock writes work again.
// [R10] port N sits at bit N; port 31 is the most significant.
// [R11] output configured with a default level drives it at once.
// [R12] ports used by timer, UART, SPI or I2C are locked automatically.
// [R13] after reset all locks are clear and all outputs are zero.
`timescale 1ns/1ps
`default_nettype none

module gio_port #(
  parameter int unsigned NPORT = gio_pkg::NPORT
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  input wire gio_pkg::gio_cmd_t CMD,
  output logic RSP_VALID,
  output logic [31:0] RSP_DATA,
  input wire logic [NPORT-1:0] PIN_IN,
  output logic [NPORT-1:0] PIN_OUT,
  output logic [NPORT-1:0] PIN_OE_N,
  output logic [NPORT-1:0] PIN_PULLUP,
  output logic [NPORT-1:0] PIN_PULLDOWN,
  input wire logic [NPORT-1:0] HDEV_OWN,
  input wire logic [NPORT-1:0] TIMER_OWN,
  output logic [NPORT-1:0] LOCK_STATE
);

  logic [NPORT-1:0] out_q;
  logic [NPORT-1:0] lock_q;
  logic [NPORT-1:0] eff_lock;
  logic [NPORT-1:0] is_out;
  logic [NPORT-1:0] level_w;
  logic [NPORT-1:0] sel_mask;
  gio_pkg::gio_mode_t mode_q [NPORT];
  gio_pkg::gio_mode_t rep_mode [NPORT];

  logic take;
  logic is_query;
  logic op_bulk_rd;
  logic op_bulk_wr;
  logic op_set_out;
  logic op_get_in;
  logic op_get_out;
  logic op_get_mode;
  logic op_set_mode;
  logic op_lock;
  logic op_unlock;

  logic pin_sel_w;
  logic out_sel_w;
  logic hdev_sel_w;
  logic timer_sel_w;
  gio_pkg::gio_mode_t mode_sel_w;
  logic [31:0] rsp_d;
  logic [31:0] rsp_q;
  logic rsp_valid_q;

  assign take = CMD_VALID;
  assign op_bulk_rd = take && (CMD.op == gio_pkg::GIO_OP_BULK_READ);
  assign op_bulk_wr = take && (CMD.op == gio_pkg::GIO_OP_BULK_WRITE);
  assign op_set_out = take && (CMD.op == gio_pkg::GIO_OP_SET_OUTPUT);
  assign op_get_in = take && (CMD.op == gio_pkg::GIO_OP_GET_INPUT);
  assign op_get_out = take && (CMD.op == gio_pkg::GIO_OP_GET_OUTPUT);
  assign op_get_mode = take && (CMD.op == gio_pkg::GIO_OP_GET_MODE);
  assign op_set_mode = take && (CMD.op == gio_pkg::GIO_OP_SET_MODE);
  assign op_lock = take && (CMD.op == gio_pkg::GIO_OP_LOCK);
  assign op_unlock = take && (CMD.op == gio_pkg::GIO_OP_UNLOCK);
  assign is_query = op_bulk_rd || op_get_in || op_get_out || op_get_mode;

  // peripheral ownership overrides the software lock
  assign eff_lock = lock_q | HDEV_OWN | TIMER_OWN; // R12
  assign LOCK_STATE = eff_lock;

  for (genvar i = 0; i < NPORT; i++) begin : g_port
    localparam logic [gio_pkg::IDXW-1:0] IDX = gio_pkg::IDXW'(i);
    logic in_rng;
    logic wr_en;
    logic wr_val;

    assign sel_mask[i] = (CMD.first == IDX); // R10
    assign in_rng = (IDX >= CMD.first) && (IDX <= CMD.last);
    assign wr_en = op_bulk_wr || (op_set_out && sel_mask[i]); // R2 R3
    assign wr_val = op_bulk_wr ? CMD.data[i] : CMD.data[0]; // R10
    // an output pin reads back what it drives, an input its pad level
    assign is_out[i] = !PIN_OE_N[i] || (mode_q[i] == gio_pkg::GIO_MODE_OUTPUT_OPEN_DRAIN);
    assign level_w[i] = is_out[i] ? out_q[i] : PIN_IN[i]; // R1
    assign rep_mode[i] = HDEV_OWN[i] ? gio_pkg::GIO_MODE_HW_PERIPHERAL : // R6
                         TIMER_OWN[i] ? gio_pkg::GIO_MODE_SOFT_TIMER_OUTPUT : // R7
                         mode_q[i];

    gio_bit u_bit (
      .clk(CLK),
      .rst_n(RSTN),
      .wr_en(wr_en),
      .wr_val(wr_val),
      .cfg_en(op_set_mode && in_rng),
      .cfg(CMD.cfg),
      .lock_set(op_lock && in_rng),
      .lock_clr(op_unlock && in_rng),
      .locked(eff_lock[i]), // R9
      .out_q(out_q[i]),
      .lock_q(lock_q[i]),
      .mode_q(mode_q[i]),
      .pin_out(PIN_OUT[i]),
      .pin_oe_n(PIN_OE_N[i]),
      .pull_up(PIN_PULLUP[i]),
      .pull_dn(PIN_PULLDOWN[i])
    );
  end

  assign pin_sel_w = PIN_IN[CMD.first];
  assign out_sel_w = out_q[CMD.first];
  assign hdev_sel_w = HDEV_OWN[CMD.first];
  assign timer_sel_w = TIMER_OWN[CMD.first];
  assign mode_sel_w = rep_mode[CMD.first];

  // queries see the state before the command in the same cycle
  assign rsp_d = op_bulk_rd ? level_w : // R1
                 op_get_in ? {31'h0000_0000, pin_sel_w} : // R4
                 op_get_out ? {31'h0000_0000, out_sel_w} : // R5
                 op_get_mode ? {28'h000_0000, mode_sel_w} : // R6 R7
                 32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rsp_q <= 32'h0000_0000;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= is_query;
      if (is_query) begin
        rsp_q <= rsp_d;
      end
    end
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rsp_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_wr_free;
    op_bulk_wr && (eff_lock == '0);
  endsequence

  sequence s_set_free;
    op_set_out && ((eff_lock & sel_mask) == '0);
  endsequence

  property p_bulk_read;
    op_bulk_rd |=> RSP_VALID && (RSP_DATA == $past(level_w));
  endproperty
  a_bulk_read: assert property (p_bulk_read) else $error("bulk read word wrong"); // R1

  property p_bulk_write;
    s_wr_free |=> (out_q == $past(CMD.data));
  endproperty
  a_bulk_write: assert property (p_bulk_write) else $error("bulk write not applied"); // R2

  property p_single_write;
    s_set_free |=> ((out_q & $past(sel_mask)) == ({NPORT{$past(CMD.data[0])}} & $past(sel_mask)))
      && (((out_q ^ $past(out_q)) & ~$past(sel_mask)) == '0);
  endproperty
  a_single_write: assert property (p_single_write) else $error("single write wrong"); // R3

  property p_get_input;
    op_get_in |=> RSP_VALID ##0 (RSP_DATA == {31'h0000_0000, $past(pin_sel_w)});
  endproperty
  a_get_input: assert property (p_get_input) else $error("input query wrong"); // R4

  property p_get_output;
    op_get_out |=> RSP_VALID && (RSP_DATA == {31'h0000_0000, $past(out_sel_w)});
  endproperty
  a_get_output: assert property (p_get_output) else $error("output query wrong"); // R5

  property p_mode_hdev;
    (op_get_mode && hdev_sel_w) |=> (RSP_DATA[3:0] == gio_pkg::GIO_MODE_HW_PERIPHERAL);
  endproperty
  a_mode_hdev: assert property (p_mode_hdev) else $error("peripheral mode not reported"); // R6

  property p_mode_timer;
    (op_get_mode && !hdev_sel_w && timer_sel_w)
      |=> (RSP_DATA[3:0] == gio_pkg::GIO_MODE_SOFT_TIMER_OUTPUT);
  endproperty
  a_mode_timer: assert property (p_mode_timer) else $error("timer mode not reported"); // R7

  property p_lock_hold;
    1'b1 |=> (((out_q ^ $past(out_q)) & $past(eff_lock)) == '0);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked output changed"); // R9

  // owned ports must hold their level whatever software writes
  property p_auto_lock;
    ((HDEV_OWN | TIMER_OWN) != '0)
      |=> (((out_q ^ $past(out_q)) & $past(HDEV_OWN | TIMER_OWN)) == '0);
  endproperty
  a_auto_lock: assert property (p_auto_lock) else $error("owned port not locked"); // R12

  // checked during reset, so the default disable must not apply here
  property p_reset_clear;
    @(posedge CLK) disable iff (1'b0)
      !RSTN |=> (out_q == '0) && (lock_q == '0) && !RSP_VALID;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // R13

  property p_default_high;
    (op_set_mode && (CMD.first == CMD.last) && (CMD.cfg.dflt == gio_pkg::GIO_DFLT_HIGH)
      && ((eff_lock & sel_mask) == '0)) |=> ((out_q & $past(sel_mask)) != '0);
  endproperty
  a_default_high: assert property (p_default_high) else $error("default high not driven"); // R11

endmodule

`default_nettype wire

// file: tb/gio_pins.sv
// pads and outside circuits seen from the port bank
`timescale 1ns/1ps
`default_nettype none

module gio_pins (
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pull_up,
  input wire logic [31:0] pull_dn,
  input wire logic [31:0] ext_lvl,
  output logic [31:0] pad_in
);
  // released pad: pulls win over the outside driver, else outside level shows
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pull_up)
                | (pad_oe_n & ~pull_up & ~pull_dn & ext_lvl);
endmodule

`default_nettype wire

// file: tb/gio_port_bench.sv
// command-level bench for the port bank
`timescale 1ns/1ps
`default_nettype none

module gio_port_bench;
  logic CLK;
  logic RSTN;
  logic CMD_VALID;
  gio_pkg::gio_cmd_t CMD;
  logic RSP_VALID;
  logic [31:0] RSP_DATA;
  logic [31:0] PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULLUP, PIN_PULLDOWN;
  logic [31:0] HDEV_OWN, TIMER_OWN, LOCK_STATE, ext_lvl;
  int fail_count = 0;
  int checked = 0;

  gio_port DUT (.CLK(CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .PIN_PULLUP(PIN_PULLUP), .PIN_PULLDOWN(PIN_PULLDOWN),
    .HDEV_OWN(HDEV_OWN), .TIMER_OWN(TIMER_OWN), .LOCK_STATE(LOCK_STATE));
  gio_pins pins (.pad_out(PIN_OUT), .pad_oe_n(PIN_OE_N), .pull_up(PIN_PULLUP),
    .pull_dn(PIN_PULLDOWN), .ext_lvl(ext_lvl), .pad_in(PIN_IN));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // one command: taken at the second edge the task waits for, the edge at which it returns
  task automatic cmd(input gio_pkg::gio_op_t o, input logic [4:0] f, input logic [4:0] l,
      input logic [31:0] d, input gio_pkg::gio_mode_t m = gio_pkg::GIO_MODE_INPUT,
      input gio_pkg::gio_dflt_t df = gio_pkg::GIO_DFLT_NONE);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD <= '{o, f, l, d, '{m, df}};
    @(posedge CLK);
    CMD_VALID <= 1'b0;
  endtask

  // query: answer stands for exactly the cycle after the taking edge
  task automatic q(input gio_pkg::gio_op_t o, input logic [4:0] f, input logic [31:0] exp);
    cmd(o, f, f, 32'h0000_0000);
    #1;
    chk("rsp_valid", 32'h0000_0001, {31'h0000_0000, RSP_VALID});
    chk("rsp_data", exp, RSP_DATA);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run is about 120 cycles
  initial begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    complete_run();
  end

  initial begin
    RSTN = 1'b0;
    CMD_VALID = 1'b0;
    CMD = '0;
    HDEV_OWN = 32'h0000_0000;
    TIMER_OWN = 32'h0000_0000;
    ext_lvl = 32'h0000_0000;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    #1;
    chk("lock_after_reset", 32'h0000_0000, LOCK_STATE);
    chk("oe_after_reset", 32'hFFFF_FFFF, PIN_OE_N);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h05, 32'h0000_0000);
    $display("test reset done");

    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h00, 5'h1F, 32'h0, gio_pkg::GIO_MODE_OUTPUT);
    cmd(gio_pkg::GIO_OP_BULK_WRITE, 5'h00, 5'h00, 32'hA5A5_3C3C);
    q(gio_pkg::GIO_OP_BULK_READ, 5'h00, 32'hA5A5_3C3C);
    cmd(gio_pkg::GIO_OP_SET_OUTPUT, 5'h1F, 5'h1F, 32'h0000_0000);
    cmd(gio_pkg::GIO_OP_SET_OUTPUT, 5'h00, 5'h00, 32'h0000_0001);
    q(gio_pkg::GIO_OP_BULK_READ, 5'h00, 32'h25A5_3C3D);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h1F, 32'h0000_0000);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h00, 32'h0000_0001);
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h07, 5'h09, 32'h0, gio_pkg::GIO_MODE_OUTPUT,
        gio_pkg::GIO_DFLT_HIGH);
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h0E, 5'h0E, 32'h0, gio_pkg::GIO_MODE_OUTPUT,
        gio_pkg::GIO_DFLT_HIGH);
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h1D, 5'h1D, 32'h0, gio_pkg::GIO_MODE_OUTPUT,
        gio_pkg::GIO_DFLT_LOW);
    #1;
    chk("pin_out_default", 32'h05A5_7FBD, PIN_OUT);
    $display("test write done");

    for (int i = 0; i < 7; i++) begin
      cmd(gio_pkg::GIO_OP_SET_MODE, 5'h14, 5'h14, 32'h0, gio_pkg::gio_mode_t'(4'(i)));
      q(gio_pkg::GIO_OP_GET_MODE, 5'h14, 32'(i));
    end
    $display("test modes done");

    cmd(gio_pkg::GIO_OP_BULK_WRITE, 5'h00, 5'h00, 32'h0000_000D);
    cmd(gio_pkg::GIO_OP_LOCK, 5'h00, 5'h03, 32'h0);
    #1;
    chk("lock_state", 32'h0000_000F, LOCK_STATE);
    cmd(gio_pkg::GIO_OP_SET_OUTPUT, 5'h00, 5'h00, 32'h0000_0000);
    cmd(gio_pkg::GIO_OP_BULK_WRITE, 5'h00, 5'h00, 32'h0000_0000);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h00, 32'h0000_0001);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h02, 32'h0000_0001);
    cmd(gio_pkg::GIO_OP_UNLOCK, 5'h00, 5'h03, 32'h0);
    cmd(gio_pkg::GIO_OP_SET_OUTPUT, 5'h00, 5'h00, 32'h0000_0000);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h00, 32'h0000_0000);
    $display("test lock done");

    @(posedge CLK);
    HDEV_OWN <= 32'h0000_0400;
    TIMER_OWN <= 32'h0000_0800;
    cmd(gio_pkg::GIO_OP_BULK_WRITE, 5'h00, 5'h00, 32'hFFFF_FFFF);
    #1;
    chk("auto_lock", 32'h0000_0C00, LOCK_STATE);
    q(gio_pkg::GIO_OP_GET_MODE, 5'h0A, 32'h0000_000E);
    q(gio_pkg::GIO_OP_GET_MODE, 5'h0B, 32'h0000_000F);
    q(gio_pkg::GIO_OP_GET_OUTPUT, 5'h0B, 32'h0000_0000);
    @(posedge CLK);
    HDEV_OWN <= 32'h0000_0000;
    TIMER_OWN <= 32'h0000_0000;
    $display("test ownership done");

    // port 20 back to plain input, outside circuit drives it
    @(posedge CLK);
    ext_lvl <= 32'h0010_0000;
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h14, 5'h14, 32'h0, gio_pkg::GIO_MODE_INPUT);
    repeat (2) @(posedge CLK);
    q(gio_pkg::GIO_OP_GET_INPUT, 5'h14, 32'h0000_0001);
    @(posedge CLK);
    ext_lvl <= 32'h0000_0000;
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h14, 5'h14, 32'h0, gio_pkg::GIO_MODE_INPUT_WITH_PULLUP);
    repeat (2) @(posedge CLK);
    q(gio_pkg::GIO_OP_GET_INPUT, 5'h14, 32'h0000_0001);
    // ports 10 and 11 stayed low while owned
    q(gio_pkg::GIO_OP_BULK_READ, 5'h00, 32'hFFFF_F3FF);
    cmd(gio_pkg::GIO_OP_SET_MODE, 5'h14, 5'h14, 32'h0, gio_pkg::GIO_MODE_INPUT_WITH_PULLDOWN);
    repeat (2) @(posedge CLK);
    q(gio_pkg::GIO_OP_GET_INPUT, 5'h14, 32'h0000_0000);
    $display("test input done");
    complete_run();
  end
endmodule

`default_nettype wire
